// [rtl/frews_pkg.sv]
package frews_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses on the APB)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_LOW_OFS = 8'h00;
   localparam logic [7:0] ADDR_HIGH_OFS = 8'h04;
   localparam logic [7:0] DATA_LOW_OFS = 8'h08;
   localparam logic [7:0] DATA_HIGH_OFS = 8'h0c;
   localparam logic [7:0] CONTROL_OFS = 8'h10;
   localparam logic [7:0] UNLOCK_OFS = 8'h14;
   // ------------------------------------------------------------
   // nvm_control field positions and reset values
   // ------------------------------------------------------------
   localparam int GO_BIT = 1;
   localparam int PERMIT_BIT = 2;
   localparam int ERASE_BIT = 4;
   localparam int LATCH_ONLY_BIT = 5;
   localparam int CFG_SEL_BIT = 6;
   localparam int PGM_SEL_BIT = 7;
   localparam logic [7:0] CONTROL_RST = 8'h00;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [13:0] LATCH_RST = 14'h3fff;
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
   // ------------------------------------------------------------
   // geometry and timing
   // ------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 14;
   localparam int N_LATCH = 32;
   localparam int LATCH_IDX_W = 5;
   localparam int CLK_PERIOD_NS = 20;
   localparam int INSN_CLKS = 4;
   localparam int SETUP_INSNS = 2;
   localparam int OP_TIME_MS = 2;
   localparam int OP_CLKS = OP_TIME_MS * 1000000 / CLK_PERIOD_NS;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_PROG, ST_WAIT} frews_state_e;
   typedef enum logic [1:0] {UL_NONE, UL_KEY1, UL_KEY2} frews_unlock_e;
   typedef struct packed {
      logic erase;
      logic prog;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } frews_flash_s;
endpackage

// [rtl/frews_top.sv]
// Function
// - program memory erase works on whole rows only, never single words.
// - go acts only right after unlock writes 55h then AAh.
// - row erase select stays readable and clears when the erase ends.
// - two instruction cycles of setup pass after go before flash work.
// - core stalls for the 2 ms erase while clocks keep running.
// - core resumes after the operation; stall drops once it completes.
// - 32 write latches; one write programs at most 32 words.
// - latch block aligned on low address boundary; writes never cross it.
// - after a program write every latch returns to 3fffh.
// - latch-only mode loads the addressed latch, no flash write, no stall.
// - normal mode loads the final latch then programs the whole block.
// - the whole latch block is programmed even if partly loaded.
// - stall only during the erase or programming operation, not latch loads.
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module frews_top
#(
   parameter int OP_CLKS = frews_pkg::OP_CLKS
)
(
   // clock and reset
   input wire logic CLK,
   input wire logic RESET_N,
   // apb slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // core and flash array
   output logic CORE_STALL,
   output frews_pkg::frews_flash_s FLASH_CMD
);
   import frews_pkg::*;

   // timer wide enough to count the whole operation time
   localparam int TW = $clog2(OP_CLKS + 1);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // base word address of the latch block holding an address
   function automatic logic [ADDR_W-1:0] row_base(input logic [ADDR_W-1:0] a);
      row_base = {a[ADDR_W-1:LATCH_IDX_W], {LATCH_IDX_W{1'b0}}};
   endfunction

   // decode of mapped offsets
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ADDR_LOW_OFS) || (a == ADDR_HIGH_OFS) || (a == DATA_LOW_OFS)
         || (a == DATA_HIGH_OFS) || (a == CONTROL_OFS) || (a == UNLOCK_OFS);
   endfunction

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   frews_state_e state_ff, nxt_state;
   frews_unlock_e unlock_ff, nxt_unlock;
   logic [ADDR_W-1:0] addr_ff, nxt_addr;
   logic [DATA_W-1:0] data_ff, nxt_data;
   logic [7:0] ctl_ff, nxt_ctl;
   // one word per write latch, erased pattern after reset
   logic [DATA_W-1:0] latch_ff [N_LATCH];
   logic [DATA_W-1:0] nxt_latch [N_LATCH];
   logic [LATCH_IDX_W-1:0] idx_ff, nxt_idx;
   logic [TW-1:0] timer_ff, nxt_timer;
   logic [1:0] div_ff, nxt_div;
   logic [1:0] setup_ff, nxt_setup;
   logic [31:0] prdata_ff, nxt_prdata;
   frews_flash_s cmd_ff, nxt_cmd;
   logic apb_wr;
   logic insn_tick;
   logic go_ok;

   // ------------------------------------------------------------
   // apb handshake
   // ------------------------------------------------------------
   // zero wait state, error on unmapped offsets
   assign PREADY = 1'b1;
   assign PSLVERR = PSEL & PENABLE & ~mapped(PADDR);
   // writes land only in the access phase of a mapped offset while idle
   assign apb_wr = PSEL & PENABLE & PWRITE & mapped(PADDR) & (state_ff == ST_IDLE);
   // one tick per instruction cycle of the core
   assign insn_tick = (div_ff == 2'(INSN_CLKS - 1));
   // go honoured only straight after the key pair with write permit set
   // permit must already stand from an earlier write, not come with this one
   assign go_ok = PWDATA[GO_BIT] & (unlock_ff == UL_KEY2) & ctl_ff[PERMIT_BIT];

   // ------------------------------------------------------------
   // instruction cycle divider
   // ------------------------------------------------------------
   // free-running so setup ends on an instruction cycle boundary
   always_comb
   begin
      nxt_div = insn_tick ? 2'h0 : div_ff + 2'h1;
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         div_ff <= 2'h0;
      else
         div_ff <= nxt_div;
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   // captured in the setup phase so PRDATA comes from a flop
   always_comb
   begin
      nxt_prdata = prdata_ff;
      if (PSEL && !PENABLE && !PWRITE)
      begin
         case (PADDR)
            ADDR_LOW_OFS: nxt_prdata = {24'h0, addr_ff[7:0]};
            ADDR_HIGH_OFS: nxt_prdata = {25'h0, addr_ff[ADDR_W-1:8]};
            DATA_LOW_OFS: nxt_prdata = {24'h0, data_ff[7:0]};
            DATA_HIGH_OFS: nxt_prdata = {26'h0, data_ff[DATA_W-1:8]};
            CONTROL_OFS: nxt_prdata = {24'h0, ctl_ff};
            default: nxt_prdata = 32'h0; // unlock and unmapped offsets read as zero
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         prdata_ff <= 32'h0;
      else
         prdata_ff <= nxt_prdata;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      nxt_unlock = unlock_ff;
      nxt_addr = addr_ff;
      nxt_data = data_ff;
      nxt_ctl = ctl_ff;
      nxt_latch = latch_ff;
      nxt_idx = idx_ff;
      nxt_timer = timer_ff;
      nxt_setup = setup_ff;
      nxt_cmd = '0;

      // register writes; any write other than a key breaks the unlock
      // dropped while busy, so address and data stay put under a running cycle
      if (apb_wr)
      begin
         nxt_unlock = UL_NONE;
         case (PADDR)
            ADDR_LOW_OFS: nxt_addr[7:0] = PWDATA[7:0];
            ADDR_HIGH_OFS: nxt_addr[ADDR_W-1:8] = PWDATA[ADDR_W-9:0];
            DATA_LOW_OFS: nxt_data[7:0] = PWDATA[7:0];
            DATA_HIGH_OFS: nxt_data[DATA_W-1:8] = PWDATA[DATA_W-9:0];
            UNLOCK_OFS:
            begin
               // a repeated first key restarts the pattern
               if (PWDATA[7:0] == UNLOCK_KEY1)
                  nxt_unlock = UL_KEY1;
               else if (PWDATA[7:0] == UNLOCK_KEY2 && unlock_ff == UL_KEY1)
                  nxt_unlock = UL_KEY2;
            end
            CONTROL_OFS:
            begin
               // go is never stored from the bus; only an accepted sequence sets it
               nxt_ctl = PWDATA[7:0];
               nxt_ctl[GO_BIT] = 1'b0;
               if (go_ok && PWDATA[LATCH_ONLY_BIT] && !PWDATA[ERASE_BIT])
               begin
                  // latch load only: no flash cycle and no stall
                  nxt_latch[addr_ff[LATCH_IDX_W-1:0]] = data_ff;
               end
               else if (go_ok)
               begin
                  // erase or program: go reads back set until the cycle completes
                  nxt_ctl[GO_BIT] = 1'b1;
                  nxt_state = ST_SETUP;
                  nxt_setup = 2'h0;
                  if (!PWDATA[ERASE_BIT])
                     nxt_latch[addr_ff[LATCH_IDX_W-1:0]] = data_ff;
               end
            end
            default: nxt_unlock = UL_NONE;
         endcase
      end

      // operation sequence
      case (state_ff)
         // block streaming always starts from word zero of the row
         ST_IDLE: nxt_idx = '0;
         ST_SETUP:
         begin
            // two instruction cycles for the core to run its nops
            // no stall yet, so the core can still fetch them
            if (insn_tick)
            begin
               nxt_setup = setup_ff + 2'h1;
               if (setup_ff == 2'(SETUP_INSNS - 1))
               begin
                  nxt_timer = '0;
                  if (ctl_ff[ERASE_BIT])
                  begin
                     // row erase only, never a single word
                     nxt_cmd.erase = 1'b1;
                     nxt_cmd.addr = row_base(addr_ff);
                     nxt_state = ST_WAIT;
                  end
                  else
                     nxt_state = ST_PROG;
               end
            end
         end
         ST_PROG:
         begin
            // stream every latch of the aligned block, loaded or not
            // one word per clock with a strictly increasing address
            nxt_cmd.prog = 1'b1;
            nxt_cmd.addr = row_base(addr_ff) | ADDR_W'(idx_ff);
            nxt_cmd.wdata = latch_ff[idx_ff];
            nxt_idx = idx_ff + 1'b1;
            if (idx_ff == LATCH_IDX_W'(N_LATCH - 1))
               nxt_state = ST_WAIT;
         end
         ST_WAIT:
         begin
            // erase and program share this wait; only a program clears the latches
            nxt_timer = timer_ff + 1'b1;
            if (timer_ff == TW'(OP_CLKS - 1))
            begin
               nxt_state = ST_IDLE;
               nxt_ctl[GO_BIT] = 1'b0;
               nxt_ctl[ERASE_BIT] = 1'b0;
               if (!ctl_ff[ERASE_BIT])
               begin
                  for (int i = 0; i < N_LATCH; i++)
                     nxt_latch[i] = LATCH_RST;
               end
            end
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // asynchronous reset leaves every latch at the erased pattern
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
      begin
         state_ff <= ST_IDLE;
         unlock_ff <= UL_NONE;
         addr_ff <= '0;
         data_ff <= '0;
         ctl_ff <= CONTROL_RST;
         for (int i = 0; i < N_LATCH; i++)
            latch_ff[i] <= LATCH_RST;
         idx_ff <= '0;
         timer_ff <= '0;
         setup_ff <= 2'h0;
         cmd_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         unlock_ff <= nxt_unlock;
         addr_ff <= nxt_addr;
         data_ff <= nxt_data;
         ctl_ff <= nxt_ctl;
         latch_ff <= nxt_latch;
         idx_ff <= nxt_idx;
         timer_ff <= nxt_timer;
         setup_ff <= nxt_setup;
         cmd_ff <= nxt_cmd;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   // stall covers flash work only, never setup or latch loads
   assign CORE_STALL = (state_ff == ST_PROG) || (state_ff == ST_WAIT);
   // registered so the array sees clean commands: a one-cycle erase pulse, a 32-cycle program burst
   assign FLASH_CMD = cmd_ff;
   assign PRDATA = prdata_ff;
endmodule
`default_nettype wire

// [verification/frews_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module frews_chk
   import frews_pkg::*;
#(parameter int OP_CLKS = 20)
(
   // watched ports of the sequencer
   input wire logic CLK,
   input wire logic RESET_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic CORE_STALL,
   input wire frews_pkg::frews_flash_s FLASH_CMD
);
   // ----------
   // helpers
   // ----------
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic go_wr;
   // go written while the core runs
   assign go_wr = PSEL && PENABLE && PWRITE && PADDR == CONTROL_OFS
      && PWDATA[GO_BIT] && !CORE_STALL;
   // length of the current stall
   always_comb nxt_cnt = CORE_STALL ? cnt_ff + 32'h1 : 32'h0;
   always_ff @(posedge CLK or negedge RESET_N)
   begin
      if (!RESET_N)
         cnt_ff <= 32'h0;
      else
         cnt_ff <= nxt_cnt;
   end
   default clocking @(posedge CLK); endclocking
   default disable iff (!RESET_N);
   property p_stall_on; FLASH_CMD.erase || FLASH_CMD.prog |-> CORE_STALL; endproperty
   a_stall_on: assert property (p_stall_on) else $error("pulse without stall");
   property p_row; FLASH_CMD.erase |-> FLASH_CMD.addr[4:0] == 5'h0 ##1 !FLASH_CMD.erase; endproperty
   a_row: assert property (p_row) else $error("erase not a whole row");
   property p_base; $rose(FLASH_CMD.prog) |-> FLASH_CMD.addr[4:0] == 5'h0; endproperty
   a_base: assert property (p_base) else $error("block not from base");
   property p_step; FLASH_CMD.prog && $past(FLASH_CMD.prog)
      |-> FLASH_CMD.addr == $past(FLASH_CMD.addr) + 15'h1; endproperty
   a_step: assert property (p_step) else $error("block address skips");
   property p_count; $rose(FLASH_CMD.prog) |-> ##31 (FLASH_CMD.prog
      && FLASH_CMD.addr[4:0] == 5'h1f) ##1 !FLASH_CMD.prog; endproperty
   a_count: assert property (p_count) else $error("word count wrong");
   property p_setup; go_wr |=> !(FLASH_CMD.erase || FLASH_CMD.prog) [*4]; endproperty
   a_setup: assert property (p_setup) else $error("setup too short");
   property p_len; $fell(CORE_STALL) |-> cnt_ff >= OP_CLKS && cnt_ff <= OP_CLKS + 33; endproperty
   a_len: assert property (p_len) else $error("stall length wrong");
   property p_load; go_wr && PWDATA[LATCH_ONLY_BIT] && !PWDATA[ERASE_BIT]
      |=> !CORE_STALL [*8]; endproperty
   a_load: assert property (p_load) else $error("latch load stalls");
endmodule
`default_nettype wire

// [verification/frews_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
module frews_core_model
(
   // apb master side of the core
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   output logic hung
);
   import frews_pkg::*;
   initial {psel, penable, pwrite, paddr, pwdata, hung} = '0;
   // one transfer, held until pready, lines scrambled after release
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      int n = 0;
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      hung <= hung | (pready !== 1'b1);
      q = prdata;
      {psel, penable, paddr, pwdata} <= {2'b0, ~a, ~d};
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      xfer(1'b1, a, {24'h0, d}, q);
   endtask
   // address, data, mode bits, then unlock and go unbroken
   task automatic op(input logic [14:0] a, input logic [13:0] d, input logic [7:0] c);
      wr(ADDR_LOW_OFS, a[7:0]);
      wr(ADDR_HIGH_OFS, {1'b0, a[14:8]});
      wr(DATA_LOW_OFS, d[7:0]);
      wr(DATA_HIGH_OFS, {2'b0, d[13:8]});
      wr(CONTROL_OFS, c);
      wr(UNLOCK_OFS, UNLOCK_KEY1);
      wr(UNLOCK_OFS, UNLOCK_KEY2);
      wr(CONTROL_OFS, c | 8'h02);
   endtask
endmodule
`default_nettype wire

// [verification/flash_row_erase_write_seq_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_row_erase_write_seq_tb;
   import frews_pkg::*;
   logic clk, reset_n, psel, penable, pwrite, pready, stall, hung, slverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   frews_flash_s fcmd;
   logic [13:0] img [32];
   logic [14:0] eaddr;
   int nprog = 0, nerase = 0, nerr = 0, err_total = 0, n_tests = 0;
   // ----------
   // harness
   // ----------
   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   frews_top #(.OP_CLKS(20)) dut (.CLK(clk), .RESET_N(reset_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(slverr), .CORE_STALL(stall), .FLASH_CMD(fcmd));
   frews_core_model core (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .hung(hung));
   // flash array image seen through the command port
   always @(posedge clk)
   begin
      if (fcmd.prog === 1'b1)
         img[fcmd.addr[4:0]] <= fcmd.wdata;
      if (fcmd.erase === 1'b1)
         eaddr <= fcmd.addr;
      nprog <= nprog + int'(fcmd.prog === 1'b1);
      nerase <= nerase + int'(fcmd.erase === 1'b1);
      nerr <= nerr + int'(psel === 1'b1 && penable === 1'b1 && slverr === 1'b1);
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // bounded wait for a stall level
   task automatic wst(input logic v);
      int n = 0;
      while (stall !== v && n < 300)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 300)
      begin
         err_total++;
         results();
      end
   endtask
   task automatic t_refuse();
      core.wr(CONTROL_OFS, 8'h86);
      core.wr(UNLOCK_OFS, 8'h55);
      core.wr(ADDR_LOW_OFS, 8'h00);
      core.wr(UNLOCK_OFS, 8'haa);
      core.wr(CONTROL_OFS, 8'h86);
      core.op(15'h0, 14'h0, 8'h80);
      core.xfer(1'b0, 8'h18, 32'h0, q);
      chk("unmapped", 32'h0, q);
      core.xfer(1'b0, CONTROL_OFS, 32'h0, q);
      chk("ctl", 32'h80, q);
      chk("slverr", 32'h1, nerr);
      chk("cmds", 32'h0, nprog + nerase);
      $display("done refuse");
   endtask
   task automatic t_erase();
      core.op(15'h0123, 14'h0, 8'h94);
      core.xfer(1'b0, CONTROL_OFS, 32'h0, q);
      chk("busy ctl", 32'h96, q);
      core.wr(ADDR_LOW_OFS, 8'h55);
      wst(1'b1);
      wst(1'b0);
      chk("row", 32'h120, eaddr);
      chk("erases", 32'h1, nerase);
      core.xfer(1'b0, CONTROL_OFS, 32'h0, q);
      chk("done ctl", 32'h84, q);
      core.xfer(1'b0, ADDR_LOW_OFS, 32'h0, q);
      chk("addr low", 32'h23, q);
      core.xfer(1'b0, ADDR_HIGH_OFS, 32'h0, q);
      chk("addr high", 32'h01, q);
      $display("done erase");
   endtask
   task automatic t_prog();
      core.op(15'h0123, 14'h1111, 8'ha4);
      core.op(15'h0125, 14'h2222, 8'ha4);
      repeat (12) @(posedge clk);
      chk("no stall", 32'h0, stall);
      core.xfer(1'b0, CONTROL_OFS, 32'h0, q);
      chk("load ctl", 32'ha4, q);
      core.op(15'h013f, 14'h0abc, 8'h84);
      wst(1'b1);
      wst(1'b0);
      chk("words", 32'd32, nprog);
      for (int i = 0; i < 32; i++)
         chk("blk1", i == 3 ? 32'h1111 : i == 5 ? 32'h2222 : i == 31 ? 32'h0abc
            : 32'h3fff, img[i]);
      core.xfer(1'b0, DATA_LOW_OFS, 32'h0, q);
      chk("data low", 32'hbc, q);
      core.xfer(1'b0, DATA_HIGH_OFS, 32'h0, q);
      chk("data high", 32'h0a, q);
      core.op(15'h0140, 14'h0555, 8'h84);
      wst(1'b1);
      wst(1'b0);
      for (int i = 0; i < 32; i++)
         chk("blk2", i == 0 ? 32'h0555 : 32'h3fff, img[i]);
      $display("done program");
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      reset_n = 1'b0;
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      t_refuse();
      t_erase();
      t_prog();
      chk("hang", 32'h0, hung);
      results();
   end
endmodule
bind frews_top frews_chk #(.OP_CLKS(OP_CLKS)) u_chk (.CLK(CLK), .RESET_N(RESET_N),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
   .CORE_STALL(CORE_STALL), .FLASH_CMD(FLASH_CMD));
`default_nettype wire
